// File: design/camera_image_pipeline.sv
`timescale 1ns/100ps
`include "cam_consts.svh"
module camera_image_pipeline import cam_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic [2:0]  cc_pin,
   input  wire logic [9:0]  pixel_in,
   input  wire logic        pixel_valid,
   input  wire logic [11:0] pixel_col,
   input  wire logic        pixel_frame_end,
   output logic [11:0]      sensor_reset_row,
   output logic             sensor_reset_strobe,
   output logic [11:0]      sensor_read_row,
   output logic             sensor_read_strobe,
   output logic             exposing,
   output logic [9:0]       out_data,
   output logic             out_valid
);
   function automatic logic [5:0] word_index(input logic [1:0] slot, input logic [3:0] idx);
      return {slot, idx};
   endfunction

   // ====================
   // register bus
   logic [31:0] ctrl;
   logic [15:0] line_clks;
   logic [31:0] roi_cols;
   logic [11:0] roi_rows;
   logic [11:0] expose_lines;
   logic [7:0]  mem_count;
   logic [7:0]  dp_addr;
   logic        dp_write;
   logic [2:0]  cmd_pulse;
   logic [9:0]  offset_tab [`TAB_DEPTH];
   logic [7:0]  gain_tab [`TAB_DEPTH];
   logic [9:0]  lut [`LUT_DEPTH];
   logic [31:0] status;
   logic [31:0] rd_mux;

   wire        ap_valid = hsel && htrans[1] && hready;
   wire [7:0]  ap_addr  = haddr[7:0];
   wire        wr_en    = dp_write;
   exp_mode_t  exp_mode;
   mem_mode_t  mem_mode;
   assign exp_mode = exp_mode_t'(ctrl[1:0]);
   assign mem_mode = mem_mode_t'(ctrl[5:4]);
   wire        cc1_low  = ctrl[2];
   wire        mem_en   = ctrl[3];
   wire        lut_en   = ctrl[6];
   wire        out8     = ctrl[7];
   wire        pix10    = ctrl[8];
   wire [2:0]  pin_en   = ctrl[11:9];
   wire [2:0]  force_on = ctrl[14:12];
   wire [11:0] roi_first = roi_cols[11:0];
   wire [11:0] roi_last  = roi_cols[27:16];

   always_comb begin
      case (ap_addr)
         `REG_CTRL:      rd_mux = ctrl;
         `REG_LINE_CLKS: rd_mux = {16'h0000, line_clks};
         `REG_ROI_COLS:  rd_mux = roi_cols;
         `REG_ROI_ROWS:  rd_mux = {20'h00000, roi_rows};
         `REG_EXPOSE:    rd_mux = {20'h00000, expose_lines};
         `REG_MEM_COUNT: rd_mux = {24'h000000, mem_count};
         `REG_STATUS:    rd_mux = status;
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_addr   <= 8'h00;
         dp_write  <= 1'b0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_write <= ap_valid && hwrite;
         dp_addr  <= ap_addr;
         if (ap_valid && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl         <= `CTRL_RESET;
         line_clks    <= `LINE_CLKS_RESET;
         roi_cols     <= `ROI_COLS_RESET;
         roi_rows     <= `ROI_ROWS_RESET;
         expose_lines <= `EXPOSE_RESET;
         mem_count    <= 8'h00;
         cmd_pulse    <= 3'h0;
      end else begin
         cmd_pulse <= (wr_en && dp_addr == `REG_CMD) ? hwdata[2:0] : 3'h0;
         if (wr_en) begin
            case (dp_addr)
               `REG_CTRL:      ctrl <= hwdata;
               `REG_LINE_CLKS: line_clks <= hwdata[15:0];
               `REG_ROI_COLS:  roi_cols <= hwdata;
               `REG_ROI_ROWS:  roi_rows <= hwdata[11:0];
               `REG_EXPOSE:    expose_lines <= hwdata[11:0];
               `REG_MEM_COUNT: mem_count <= hwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // tables unreset: load before use
   always_ff @(posedge hclk) begin
      if (wr_en && dp_addr == `REG_TABLE_WR) begin
         case (hwdata[31:30])
            2'h0:    offset_tab[hwdata[19:16]] <= hwdata[9:0];
            2'h1:    gain_tab[hwdata[19:16]] <= hwdata[7:0];
            2'h2:    lut[hwdata[25:16]] <= hwdata[9:0];
            default: ;
         endcase
      end
   end

   // ====================
   // control inputs
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic [2:0] cc_lvl;
   logic [2:0] cc_prev;

   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            sync1[i]  <= 1'b0;
            sync2[i]  <= 1'b0;
            sync3[i]  <= 1'b0;
            cc_lvl[i] <= 1'b0;
         end else begin
            sync1[i] <= cc_pin[i];
            sync2[i] <= sync1[i];
            sync3[i] <= sync2[i];
            if (sync2[i] == sync3[i]) begin
               cc_lvl[i] <= sync3[i];
            end
         end
      end
   end

   wire [2:0] pin_act  = cc_lvl ^ {2'b00, cc1_low};
   wire [2:0] cc_eff   = (pin_en & pin_act) | force_on;
   wire [2:0] cc_event = (cc_eff & ~cc_prev) | cmd_pulse;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cc_prev <= 3'h0;
      end else begin
         cc_prev <= cc_eff;
      end
   end

   // ====================
   // line timing and rolling shutter
   logic [1:0]    div_cnt;
   logic [15:0]   line_cnt;
   logic [11:0]   expose_left;
   logic          rst_active;
   logic          rd_active;
   logic          read_pend;
   expose_state_t ex_state;
   expose_state_t next_ex_state;

   wire [11:0] roi_width   = roi_last - roi_first + 12'h001;
   wire [15:0] line_min    = ({1'b0, roi_width} < `NARROW_COLS) ? `LINE_MIN_NARROW : `LINE_MIN_FULL;
   wire [15:0] line_period = (line_clks > line_min) ? line_clks : line_min;
   wire        sensor_tick = (div_cnt == `SENSOR_DIV - 2'd1);
   wire        line_tick   = sensor_tick && (line_cnt == line_period - 16'h0001);
   wire        cc1_active  = cc_eff[0];
   wire        start_free  = (exp_mode == EXP_FREE) && !rst_active;
   wire        start_edge  = (exp_mode == EXP_EDGE) && cc_event[0];
   wire        start_level = (exp_mode == EXP_LEVEL) && cc1_active && !cc_prev[0];
   wire        can_start   = (ex_state == EX_IDLE) && !read_pend;
   wire        start_frame = can_start && (start_free || start_edge || start_level);
   wire        expose_done = (ex_state == EX_EXPOSE) && exp_mode != EXP_LEVEL && line_tick && expose_left == 12'h000;
   wire        read_go     = expose_done || ((ex_state == EX_ENDING) && line_tick);
   // row 0 is read on the very tick exposure ends if no readout is active, so exposure is exactly the programmed lines; otherwise read_pend holds it for a later tick
   wire        rd_begin    = line_tick && (read_go || read_pend) && !rd_active;
   wire        rst_last    = sensor_reset_row == roi_rows - 12'h001;
   wire        rd_end      = sensor_read_row == roi_rows - 12'h001;

   always_comb begin
      case (ex_state)
         EX_IDLE:   next_ex_state = start_frame ? EX_EXPOSE : EX_IDLE;
         EX_EXPOSE: next_ex_state = (exp_mode == EXP_LEVEL) ? (cc1_active ? EX_EXPOSE : EX_ENDING)
                                  : (expose_done ? EX_IDLE : EX_EXPOSE);
         EX_ENDING: next_ex_state = line_tick ? EX_IDLE : EX_ENDING;
         default:   next_ex_state = EX_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt  <= 2'd0;
         line_cnt <= 16'h0000;
         ex_state <= EX_IDLE;
      end else begin
         div_cnt  <= sensor_tick ? 2'd0 : div_cnt + 2'd1;
         ex_state <= next_ex_state;
         if (line_tick) begin
            line_cnt <= 16'h0000;
         end else if (sensor_tick) begin
            line_cnt <= line_cnt + 16'h0001;
         end
      end
   end

   // the reset sweep of frame n+1 may run while frame n is still being read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         expose_left         <= 12'h000;
         rst_active          <= 1'b0;
         rd_active           <= 1'b0;
         read_pend           <= 1'b0;
         sensor_reset_row    <= 12'h000;
         sensor_read_row     <= 12'h000;
         sensor_reset_strobe <= 1'b0;
         sensor_read_strobe  <= 1'b0;
         exposing            <= 1'b0;
      end else begin
         sensor_reset_strobe <= line_tick && rst_active && !rst_last;
         sensor_read_strobe  <= rd_begin || (line_tick && rd_active && !rd_end);
         exposing            <= (ex_state != EX_IDLE);
         if (start_frame) begin
            rst_active       <= 1'b1;
            sensor_reset_row <= 12'hfff;
            expose_left      <= expose_lines;
         end else if (line_tick && rst_active) begin
            rst_active       <= !rst_last;
            sensor_reset_row <= sensor_reset_row + 12'h001;
         end
         if (line_tick && ex_state == EX_EXPOSE && expose_left != 12'h000) begin
            expose_left <= expose_left - 12'h001;
         end
         if (rd_begin) begin
            read_pend <= 1'b0;
         end else if (read_go) begin
            read_pend <= 1'b1;
         end
         if (rd_begin) begin
            rd_active       <= 1'b1;
            sensor_read_row <= 12'h000;
         end else if (line_tick && rd_active) begin
            rd_active       <= !rd_end;
            sensor_read_row <= sensor_read_row + 12'h001;
         end
      end
   end

   // ====================
   // offset and gain correction
   logic [9:0] corrected_pixel;
   logic       corr_valid;
   logic       corr_end;

   wire        in_roi    = pixel_col >= roi_first && pixel_col <= roi_last;
   wire [11:0] col_off   = pixel_col - roi_first;
   wire [3:0]  tab_idx   = col_off[3:0];
   wire [9:0]  dark      = offset_tab[tab_idx];
   wire [9:0]  diff      = (pixel_in > dark) ? pixel_in - dark : 10'h000;
   wire [17:0] product   = diff * gain_tab[tab_idx];
   wire [10:0] scaled    = product[17:7];
   wire [10:0] pixel_max_value = pix10 ? `FULL_10 : `FULL_8;
   wire [10:0] saturated = (scaled >= pixel_max_value) ? pixel_max_value : scaled;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         corrected_pixel <= 10'h000;
         corr_valid      <= 1'b0;
         corr_end        <= 1'b0;
      end else begin
         corrected_pixel <= saturated[9:0];
         corr_valid      <= pixel_valid && in_roi;
         corr_end        <= pixel_frame_end;
      end
   end

   // ====================
   // image memory
   logic [31:0] mem [`NUM_SLOTS*`SLOT_PIX];
   logic [1:0]  wr_slot;
   logic [1:0]  rd_slot;
   logic [2:0]  count;
   logic [4:0]  pix_idx;
   logic [7:0]  sum_frames;
   logic [7:0]  delay_left;
   logic        triggered;
   logic        stopped;
   logic [3:0]  req_pend;
   logic        rd_busy;
   logic [3:0]  rd_idx;
   logic [1:0]  byte_sel;

   wire        is_sum    = mem_mode == MEM_SUM;
   wire        is_circ   = mem_mode == MEM_CIRC;
   wire        clear     = cc_event[2];
   wire        not_full  = count < 3'(`NUM_SLOTS);
   wire        cap_ok    = mem_en && (is_circ ? !stopped : not_full);
   wire        cap_wr    = cap_ok && corr_valid && !pix_idx[4];
   wire        commit    = cap_ok && corr_end;
   wire        sum_adv   = is_sum && (sum_frames + 8'h01 >= mem_count);
   wire        slot_done = commit && (!is_sum || sum_adv);
   wire        cc2_trig  = is_circ && cc_event[1] && !triggered;
   wire [5:0]  wr_word   = word_index(wr_slot, pix_idx[3:0]);
   wire [5:0]  rd_word   = word_index(rd_slot, rd_idx);
   wire [31:0] rd_data   = mem[rd_word];
   wire        rd_start  = mem_en && !rd_busy && req_pend != 4'h0 && count != 3'h0
                           && (!is_circ || stopped);
   wire        word_end  = !is_sum || byte_sel == 2'd3;
   wire        rd_last   = rd_busy && word_end && rd_idx == 4'(`SLOT_PIX - 1);
   wire        overwrite = is_circ && slot_done && !not_full;
   wire        cnt_inc   = slot_done && !overwrite;
   wire        req_inc   = cc_event[1] && req_pend != 4'hf;

   // summed words are cleared as they leave
   always_ff @(posedge hclk) begin
      if (cap_wr) begin
         mem[wr_word] <= (is_sum && sum_frames != 8'h00) ? mem[wr_word] + {22'h000000, corrected_pixel}
                                                          : {22'h000000, corrected_pixel};
      end
      if (rd_busy && is_sum && word_end) begin
         mem[rd_word] <= 32'h0000_0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_slot <= 2'h0;
         rd_slot <= 2'h0;
         count   <= 3'h0;
         pix_idx <= 5'h00;
         sum_frames <= 8'h00;
         delay_left <= 8'h00;
         triggered <= 1'b0;
         stopped <= 1'b0;
         req_pend <= 4'h0;
         rd_busy <= 1'b0;
         rd_idx  <= 4'h0;
         byte_sel <= 2'd0;
      end else if (clear) begin
         wr_slot <= 2'h0;
         rd_slot <= 2'h0;
         count   <= 3'h0;
         pix_idx <= 5'h00;
         sum_frames <= 8'h00;
         triggered <= 1'b0;
         stopped <= 1'b0;
         req_pend <= 4'h0;
         rd_busy <= 1'b0;
      end else begin
         if (corr_end) begin
            pix_idx <= 5'h00;
         end else if (cap_wr) begin
            pix_idx <= pix_idx + 5'h01;
         end
         if (commit && is_sum) begin
            sum_frames <= sum_adv ? 8'h00 : sum_frames + 8'h01;
         end
         if (slot_done) begin
            wr_slot <= wr_slot + 2'h1;
         end
         // an overwrite drops the oldest image
         if (rd_last || overwrite) begin
            rd_slot <= rd_slot + 2'h1;
         end
         count <= count + {2'b00, cnt_inc} - {2'b00, rd_last && !overwrite};
         if (cc2_trig) begin
            triggered  <= 1'b1;
            delay_left <= mem_count;
            stopped    <= (mem_count == 8'h00);
         end else if (triggered && commit && !stopped) begin
            delay_left <= delay_left - 8'h01;
            stopped    <= (delay_left <= 8'h01);
         end
         // a request arriving as another completes is still counted
         req_pend <= req_pend + {3'b000, req_inc} - {3'b000, rd_last};
         if (rd_start) begin
            rd_busy  <= 1'b1;
            rd_idx   <= 4'h0;
            byte_sel <= 2'd0;
         end else if (rd_busy) begin
            byte_sel <= is_sum ? byte_sel + 2'd1 : 2'd0;
            if (word_end) begin
               rd_idx <= rd_idx + 4'h1;
            end
            if (rd_last) begin
               rd_busy <= 1'b0;
            end
         end
      end
   end

   // ====================
   // lookup table and output funnel
   wire [9:0] pick     = mem_en ? rd_data[9:0] : corrected_pixel;
   wire       use_lut  = lut_en && !(mem_en && is_sum);
   wire [9:0] lut_val  = use_lut ? lut[pick] : pick;
   wire [7:0] sum_byte = rd_data[8*byte_sel +: 8];
   wire [9:0] funnel   = (mem_en && is_sum) ? {2'b00, sum_byte}
                       : out8 ? {2'b00, lut_val[9:2]} : lut_val;
   wire       src_vld  = mem_en ? rd_busy : corr_valid;

   assign status = {16'h0000, req_pend, 1'b0, count, 2'b00, rd_busy, stopped, triggered, exposing, rd_active,
                    rst_active};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_data  <= 10'h000;
         out_valid <= 1'b0;
      end else begin
         out_data  <= funnel;
         out_valid <= src_vld;
      end
   end
endmodule // camera_image_pipeline

// File: design/cam_consts.svh
// What this block does
// - free, edge and level exposure with polarity
// - each edge starts one frame; busy edges ignored
// - readout of one frame overlaps next exposure
// - level asserted resets sensor; deasserted starts readout
// - level exposure ends at end of line
// - reset row leads read row by exposure lines
// - line at least 132, full width 153 clocks
// - clocks-per-line setting lengthens the line period
// - only region-of-interest pixels are processed
// - subtract dark offset, clamp negatives to zero
// - gain is 1.7 fixed point, times 2/256
// - corrected pixel saturates at full scale
// - memory option routes pixels into image memory
// - fifo fills until full, requests pop oldest
// - circular overwrites oldest, stops after delayed count
// - after stop, each request sends oldest image
// - stopped circular memory waits for clear to re-arm
// - summing into 32-bit buffers, advance, halt when full
// - sum buffer cleared on readout, early requests wait
// - lookup table maps pixels, totals bypass it
// - 8-bit output sends upper bits; totals little-endian
// - serial clear or third input edge clears memory
// - control inputs replaceable by command or forced
`ifndef CAM_CONSTS_SVH
`define CAM_CONSTS_SVH
`define REG_CTRL        8'h00
`define REG_LINE_CLKS   8'h04
`define REG_ROI_COLS    8'h08
`define REG_ROI_ROWS    8'h0c
`define REG_EXPOSE      8'h10
`define REG_MEM_COUNT   8'h14
`define REG_CMD         8'h18
`define REG_TABLE_WR    8'h1c
`define REG_STATUS      8'h20
`define CTRL_RESET      32'h0000_0100
`define LINE_CLKS_RESET 16'h0000
`define ROI_COLS_RESET  32'h092f_0000
`define ROI_ROWS_RESET  12'h010
`define EXPOSE_RESET    12'h004
`define SENSOR_DIV      2'd3
`define LINE_MIN_NARROW 16'd132
`define LINE_MIN_FULL   16'd153
`define NARROW_COLS     13'd2048
`define FULL_8          11'd255
`define FULL_10         11'd1023
`define NUM_SLOTS       4
`define SLOT_PIX        16
`define TAB_DEPTH       16
`define LUT_DEPTH       1024
`endif

// File: design/cam_pkg.sv
package cam_pkg;
   typedef enum logic [1:0] {EXP_FREE = 2'h0, EXP_EDGE = 2'h1, EXP_LEVEL = 2'h2} exp_mode_t;
   typedef enum logic [1:0] {MEM_FIFO = 2'h0, MEM_CIRC = 2'h1, MEM_SUM = 2'h2} mem_mode_t;
   typedef enum logic [2:0] {EX_IDLE = 3'h1, EX_EXPOSE = 3'h2, EX_ENDING = 3'h4} expose_state_t;
endpackage

// File: verif/cam_props.sv
`timescale 1ns/100ps
`include "cam_consts.svh"
// ====================
// port checker
module cam_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        pixel_valid,
   input wire logic [11:0] sensor_read_row,
   input wire logic        sensor_read_strobe,
   input wire logic [9:0]  out_data,
   input wire logic        out_valid
);
   logic        a_wr;
   logic        a_rd;
   logic [7:0]  a_ad;
   logic [31:0] ctrl;
   logic [9:0]  gap;
   logic [11:0] last_row;
   wire         take = hsel && htrans[1] && hready;
   // mode shadow for path checks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_wr <= 1'b0;
         a_rd <= 1'b0;
         a_ad <= 8'h00;
         ctrl <= 32'h0000_0100;
         gap <= 10'h3ff;
         last_row <= 12'hfff;
      end else begin
         a_wr <= take && hwrite;
         a_rd <= take && !hwrite;
         a_ad <= haddr[7:0];
         if (a_wr && a_ad == `REG_CTRL)
            ctrl <= hwdata;
         gap <= sensor_read_strobe ? 10'h000 : (gap == 10'h3ff ? gap : gap + 10'h001);
         if (sensor_read_strobe)
            last_row <= sensor_read_row;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence word_run;
      out_valid [*8] ##1 out_valid [*8] ##1 !out_valid;
   endsequence
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   okay_resp_a: assert property (!hresp) else $error("hresp not okay");
   unmapped_zero_a: assert property (a_rd && (a_ad > 8'h20 || a_ad == 8'h18 || a_ad == 8'h1c) |-> hrdata == 32'h0)
      else $error("unmapped read");
   direct_path_a: assert property (out_valid && !ctrl[3] |-> $past(pixel_valid, 2))
      else $error("stray word");
   sat_limit_a: assert property (out_valid && !ctrl[3] && ctrl[8:6] == 3'b000 |-> out_data <= 10'h0ff)
      else $error("over full scale");
   line_min_a: assert property (sensor_read_strobe |-> gap >= 10'd395)
      else $error("short line");
   row_step_a: assert property (sensor_read_strobe |-> sensor_read_row == last_row + 12'h1 || sensor_read_row == 12'h0)
      else $error("read row skipped");
   fifo_burst_a: assert property ($rose(out_valid) && ctrl[3] && !ctrl[5] |-> word_run)
      else $error("burst length");
endmodule // cam_props
bind camera_image_pipeline cam_props i_cam_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hreadyout, .hrdata, .hresp, .pixel_valid, .sensor_read_row, .sensor_read_strobe, .out_data, .out_valid);

// File: verif/cam_host_model.sv
`timescale 1ns/100ps
// ====================
// grabber side: control lines and raw pixel feed
module cam_host_model (
   input  wire logic       hclk,
   input  wire logic       lclk,
   input  wire logic [2:0] cc_level,
   input  wire logic       feed_go,
   input  wire logic [9:0] feed_base,
   output logic [2:0]      cc_pin,
   output logic [9:0]      pixel_in,
   output logic            pixel_valid,
   output logic [11:0]     pixel_col,
   output logic            pixel_frame_end
);
   logic [4:0] n = 5'd17;
   initial {cc_pin, pixel_in, pixel_valid, pixel_col, pixel_frame_end} = '0;
   always @(posedge lclk) cc_pin <= cc_level;
   // idle data lines toggle so stale values cannot pass
   always @(posedge hclk) begin
      pixel_frame_end <= (n == 5'd16);
      pixel_valid <= (n < 5'd16);
      pixel_in <= (n < 5'd16) ? feed_base + {n[3:0], 6'h0} : ~pixel_in;
      pixel_col <= (n < 5'd16) ? {8'h0, n[3:0]} : ~pixel_col;
      n <= feed_go ? 5'd0 : (n < 5'd17 ? n + 5'd1 : n);
   end
endmodule // cam_host_model

// File: verif/camera_image_pipeline_test.sv
`timescale 1ns/100ps
`include "cam_consts.svh"
module camera_image_pipeline_test;
   logic        hclk = 1'b0;
   logic        lclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [2:0]  cc_level = 3'h0;
   logic        feed_go = 1'b0;
   logic [9:0]  feed_base = 10'h0;
   logic        hreadyout, hresp, pixel_valid, pixel_frame_end, sensor_reset_strobe, sensor_read_strobe;
   logic        exposing, out_valid;
   logic [31:0] hrdata;
   logic [2:0]  cc_pin;
   logic [9:0]  pixel_in, out_data;
   logic [11:0] pixel_col, sensor_reset_row, sensor_read_row;
   wire         hready = hreadyout;
   logic [9:0]  q[$];
   int          err_count = 0;
   int          tests_run = 0;
   always #2.5 hclk = ~hclk;
   always #40 lclk = ~lclk;
   camera_image_pipeline i_camera_image_pipeline (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hrdata, .hresp, .cc_pin, .pixel_in, .pixel_valid, .pixel_col,
      .pixel_frame_end, .sensor_reset_row, .sensor_reset_strobe, .sensor_read_row, .sensor_read_strobe,
      .exposing, .out_data, .out_valid);
   cam_host_model i_cam_host_model (.hclk, .lclk, .cc_level, .feed_go, .feed_base, .cc_pin, .pixel_in,
      .pixel_valid, .pixel_col, .pixel_frame_end);
   always @(posedge hclk) if (out_valid === 1'b1) q.push_back(out_data);
   // ====================
   // shared tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk("register", e, r & m);
   endtask
   task automatic feed(input logic [9:0] b);
      feed_base <= b;
      feed_go <= 1'b1;
      @(posedge hclk);
      feed_go <= 1'b0;
      repeat (20) @(posedge hclk);
   endtask
   function automatic int corr(int i, int b, int full);
      int d;
      d = b + 64 * i - (i % 2 ? 1000 : 16);
      if (d < 0) d = 0;
      d = (d * (32 + 14 * i)) >> 7;
      return d > full ? full : d;
   endfunction
   task automatic frame(input int b, input logic [31:0] cfg);
      int v;
      while (q.size() < 16) @(posedge hclk);
      for (int i = 0; i < 16; i++) begin
         v = corr(i, b, cfg[8] ? 1023 : 255);
         if (cfg[6]) v = 1023 - v;
         if (cfg[7]) v = v >> 2;
         chk("pixel", 32'(v), 32'(q[i]));
      end
      q.delete();
   endtask
   task automatic sum(input int b1, input int b2);
      int s;
      wr(`REG_CMD, 32'h2);
      while (q.size() < 64) @(posedge hclk);
      for (int k = 0; k < 64; k++) begin
         s = corr(k / 4, b1, 1023) + corr(k / 4, b2, 1023);
         chk("total byte", 32'((s >> (8 * (k % 4))) & 255), 32'(q[k]));
      end
      q.delete();
   endtask
   // ====================
   // scenarios
   task automatic t_regs();
      rd(`REG_CTRL, 32'h100);
      rd(`REG_ROI_COLS, 32'h092f_0000);
      rd(`REG_ROI_ROWS, 32'h10);
      rd(`REG_EXPOSE, 32'h4);
      rd(8'h40, 32'h0);
      rd(`REG_CMD, 32'h0);
      wr(`REG_LINE_CLKS, 32'hc8);
      rd(`REG_LINE_CLKS, 32'hc8);
      wr(`REG_CTRL, 32'h101);
      for (int i = 0; i < 16; i++) begin
         wr(`REG_TABLE_WR, 32'((i << 16) | (i % 2 ? 1000 : 16)));
         wr(`REG_TABLE_WR, 32'(32'h4000_0000 | (i << 16) | (32 + 14 * i)));
      end
      for (int v = 0; v < 1024; v++) wr(`REG_TABLE_WR, 32'(32'h8000_0000 | (v << 16) | (1023 - v)));
      $display("test regs done");
   endtask
   task automatic t_path();
      logic [31:0] cfg [4] = '{32'h101, 32'h181, 32'h001, 32'h141};
      for (int c = 0; c < 4; c++) begin
         wr(`REG_CTRL, cfg[c]);
         feed(10'h20);
         frame(32, cfg[c]);
      end
      $display("test path done");
   endtask
   task automatic t_fifo();
      wr(`REG_CTRL, 32'hd09);
      wr(`REG_CMD, 32'h4);
      feed(10'h20);
      feed(10'h28);
      chk("early words", 0, q.size());
      rd(`REG_STATUS, 32'h200, 32'h700);
      wr(`REG_CMD, 32'h2);
      frame(32, 32'h100);
      cc_level <= 3'h2;
      frame(40, 32'h100);
      cc_level <= 3'h0;
      feed(10'h20);
      cc_level <= 3'h4;
      repeat (40) @(posedge hclk);
      cc_level <= 3'h0;
      repeat (40) @(posedge hclk);
      rd(`REG_STATUS, 32'h0, 32'h700);
      wr(`REG_CMD, 32'h2);
      repeat (30) @(posedge hclk);
      chk("pre words", 0, q.size());
      feed(10'h28);
      frame(40, 32'h100);
      $display("test fifo done");
   endtask
   task automatic t_sum();
      wr(`REG_CTRL, 32'h129);
      wr(`REG_MEM_COUNT, 32'h2);
      wr(`REG_CMD, 32'h4);
      feed(10'h20);
      feed(10'h28);
      sum(32, 40);
      feed(10'h28);
      feed(10'h28);
      sum(40, 40);
      $display("test sum done");
   endtask
   task automatic t_expose();
      int n;
      wr(`REG_CTRL, 32'h101);
      repeat (16000) @(posedge hclk);
      wr(`REG_CMD, 32'h1);
      while (sensor_reset_strobe !== 1'b1) @(negedge hclk);
      for (n = 0; sensor_read_strobe !== 1'b1; n++) @(negedge hclk);
      chk("exposure span", 1, 32'(n >= 2398 && n <= 2402));
      repeat (10000) @(posedge hclk);
      wr(`REG_CTRL, 32'h302);
      cc_level <= 3'h1;
      repeat (60) @(posedge hclk);
      chk("exposing", 1, 32'(exposing));
      repeat (1000) @(posedge hclk);
      cc_level <= 3'h0;
      for (n = 0; sensor_read_strobe !== 1'b1; n++) @(negedge hclk);
      chk("level read start", 1, 32'(n <= 1240));
      $display("test expose done");
   endtask
   task automatic summarize();
      $display("tests %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_path();
      t_fifo();
      t_sum();
      t_expose();
      summarize();
   end
   initial begin
      #500000;
      err_count++;
      summarize();
   end
endmodule // camera_image_pipeline_test
